// >>> hw/dlef_pkg.sv
/*
 * Shared constants and carriers for the debug link error flag block.
 * Assumes one core clock domain; all command and mode inputs come from
 * logic on that clock.
 */
package dlef_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Status register layout
    localparam int unsigned OVERRUN_BIT = 4;
    localparam int unsigned NO_RESPONSE_BIT = 3;
    localparam int unsigned READ_INVALID_BIT = 2;
    localparam int unsigned ILLEGAL_ACCESS_BIT = 1;
    localparam int unsigned ILLEGAL_COMMAND_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] FILL_BYTE = 8'hEE;

    ////////////////////////////////////////////////////////////////////////
    // Cycle counts
    localparam int unsigned FREE_CYCLE_TIMEOUT = 512;
    localparam int unsigned ACK_CYCLES = 16;
    localparam int unsigned LONG_ACK_CYCLES = 64;
    localparam int unsigned ACK_CNT_W = 7;

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT_CYCLE = 4'b0010,
        ST_ACCESS = 4'b0100,
        ST_ACK = 4'b1000
    } dlef_state_e;

    // Decoded command properties, valid with the command start pulse
    typedef struct packed {
        logic opcodeUnimpl;
        logic seqIllegal;
        logic activeOnly;
        logic alwaysAvail;
        logic isRead;
        logic isWrite;
        logic memAccess;
        logic samplePc;
        logic cpuRegAccess;
        logic enterDebug;
        logic singleStep;
        logic addrUnimpl;
        logic flashTarget;
        logic badCpuReg;
    } dlef_cmd_s;

    // Device mode and control levels
    typedef struct packed {
        logic ackEnable;
        logic stealSelect;
        logic ctrlEnabled;
        logic debugModeActive;
        logic massErase;
        logic secured;
        logic stopMode;
        logic stopClockKeep;
        logic waitMode;
        logic awaitWaitReturn;
        logic enteringWait;
    } dlef_mode_s;

endpackage : dlef_pkg

// >>> hw/dlef_free_timer.sv
/*
 * Free-cycle timeout counter: counts core clocks while enabled and
 * pulses once when the limit is reached.
 * Assumes run is a level from the same clock domain.
 */
`timescale 1ns/1ns
module dlef_free_timer import dlef_pkg::*; #(
    parameter int unsigned LIMIT = FREE_CYCLE_TIMEOUT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control and result
    input wire logic run,
    output logic expired
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    // Count while running, restart whenever stopped
    always_comb begin
        count_next = '0;
        if (run && count_reg != LAST) begin
            count_next = count_reg + CW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Expiry in the cycle that completes the limit
    assign expired = run && (count_reg == LAST);

endmodule : dlef_free_timer

// >>> hw/dlef_error_flags.sv
/*
 * Error and status flags of the single-wire debug controller: overrun,
 * no-response, read-invalid, illegal access and illegal command, with the
 * access sequencer that raises them and the acknowledge pulse on the pin.
 * Assumes a command decoder and core bus on ref_clk; the debug pin arrives
 * asynchronously and is synchronised here.
 */
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
module dlef_error_flags import dlef_pkg::*; #(
    parameter int unsigned TIMEOUT = FREE_CYCLE_TIMEOUT,
    parameter int unsigned ACK_LEN = ACK_CYCLES,
    parameter int unsigned LONG_ACK_LEN = LONG_ACK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Debug pin
    input wire logic debugPinIn,
    output logic debugPinOut,
    output logic debugPinOeN,
    // Command decoder
    input wire logic cmdStart,
    input wire dlef_cmd_s cmdInfo,
    input wire logic hostRetrieve,
    input wire logic syncSeen,
    // Status register write
    input wire logic statusWr,
    input wire logic [7:0] statusWrData,
    // Device mode
    input wire dlef_mode_s modeInfo,
    // Internal bus
    input wire logic freeCycle,
    input wire logic accDone,
    input wire logic eccError,
    input wire logic externalWait,
    input wire logic [7:0] accRdData,
    output logic accReq,
    output logic accSteal,
    output logic accAbort,
    // Results
    output logic enterDebugReq,
    output logic [7:0] statusLow,
    output logic [7:0] readData
);
    localparam logic [ACK_CNT_W-1:0] ACK_LOAD = ACK_CNT_W'(ACK_LEN - 1);
    localparam logic [ACK_CNT_W-1:0] LONG_LOAD = ACK_CNT_W'(LONG_ACK_LEN - 1);

    //////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic pinMeta_reg;
    logic pinSync_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinMeta_reg <= 1'b1;
            pinSync_reg <= 1'b1;
        end else begin
            pinMeta_reg <= debugPinIn;
            pinSync_reg <= pinMeta_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State and flags
    dlef_state_e state_reg, state_next;
    logic [ACK_CNT_W-1:0] ackCnt_reg, ackCnt_next;
    logic overrun_reg, overrun_next;
    logic no_response_flag_reg, no_response_flag_next;
    logic readInv_reg, readInv_next;
    logic illegal_access_flag_reg, illegal_access_flag_next;
    logic illegal_command_flag_reg, illegal_command_flag_next;
    logic abortPend_reg, abortPend_next;
    logic writeAcc_reg, writeAcc_next;
    logic readAcc_reg, readAcc_next;
    logic enterPend_reg, enterPend_next;
    logic [7:0] readData_reg, readData_next;
    logic timeout;
    logic setOverrun, blocked, cmdIllegal, accIllegal, stopRefuse, waitRefuse;
    logic setNoResp, needsAccess, inFlight, handshakeLoose, looseLate, startAcc;

    dlef_free_timer #(
        .LIMIT(TIMEOUT)
    ) u_free_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .run(state_reg == ST_WAIT_CYCLE && modeInfo.ackEnable && !modeInfo.stealSelect),
        .expired(timeout)
    );

    // Command classification and flag set terms
    always_comb begin
        inFlight = (state_reg == ST_WAIT_CYCLE) || (state_reg == ST_ACCESS);
        handshakeLoose = !modeInfo.ackEnable || modeInfo.stealSelect;
        setOverrun = (cmdStart && ((inFlight && modeInfo.ackEnable) || state_reg == ST_ACK))
            || (modeInfo.ackEnable && inFlight && !pinSync_reg && debugPinOeN);
        blocked = overrun_reg || setOverrun;
        cmdIllegal = cmdInfo.opcodeUnimpl || cmdInfo.seqIllegal
            || (cmdInfo.activeOnly && !modeInfo.debugModeActive)
            || (!cmdInfo.alwaysAvail && (!modeInfo.ctrlEnabled || modeInfo.massErase || modeInfo.secured));
        accIllegal = !cmdIllegal && (cmdInfo.addrUnimpl || (cmdInfo.isWrite && cmdInfo.flashTarget)
            || (cmdInfo.cpuRegAccess && cmdInfo.badCpuReg));
        stopRefuse = modeInfo.stopMode && !modeInfo.stopClockKeep
            && (cmdInfo.memAccess || cmdInfo.samplePc);
        waitRefuse = modeInfo.waitMode && (cmdInfo.enterDebug || cmdInfo.cpuRegAccess);
        looseLate = handshakeLoose && inFlight
            && (hostRetrieve || (cmdStart && writeAcc_reg));
        needsAccess = cmdInfo.memAccess || cmdInfo.samplePc || cmdInfo.cpuRegAccess;
        startAcc = cmdStart && state_reg == ST_IDLE && !blocked && !cmdIllegal && !accIllegal
            && needsAccess && !stopRefuse && !waitRefuse;
        setNoResp = timeout
            || looseLate
            || (cmdStart && (stopRefuse || waitRefuse))
            || (cmdStart && modeInfo.awaitWaitReturn)
            || (cmdStart && cmdInfo.singleStep && modeInfo.ctrlEnabled && modeInfo.enteringWait);
    end

    //////////////////////////////////////////////////////////////////////////
    // Flag next values: a set always wins over a clear
    always_comb begin
        overrun_next = setOverrun ? 1'b1 : (syncSeen ? 1'b0 : overrun_reg);
        no_response_flag_next = setNoResp ? 1'b1
            : ((statusWr && statusWrData[NO_RESPONSE_BIT]) ? 1'b0 : no_response_flag_reg);
        readInv_next = (state_reg == ST_ACCESS && accDone && readAcc_reg && eccError) ? 1'b1
            : ((statusWr && statusWrData[READ_INVALID_BIT]) ? 1'b0 : readInv_reg);
        illegal_access_flag_next = (cmdStart && accIllegal) ? 1'b1
            : ((statusWr && statusWrData[ILLEGAL_ACCESS_BIT]) ? 1'b0 : illegal_access_flag_reg);
        illegal_command_flag_next = (cmdStart && cmdIllegal) ? 1'b1
            : ((statusWr && statusWrData[ILLEGAL_COMMAND_BIT]) ? 1'b0 : illegal_command_flag_reg);
    end

    //////////////////////////////////////////////////////////////////////////
    // Access sequencer, abort and acknowledge
    always_comb begin
        state_next = state_reg;
        ackCnt_next = ackCnt_reg;
        abortPend_next = abortPend_reg;
        writeAcc_next = writeAcc_reg;
        readAcc_next = readAcc_reg;
        readData_next = readData_reg;
        enterPend_next = enterPend_reg;
        // Enter-debug held across wait mode, issued on wait exit
        if (cmdStart && cmdInfo.enterDebug && !cmdIllegal && !blocked) begin
            enterPend_next = 1'b1;
        end else if (enterPend_reg && !modeInfo.waitMode) begin
            enterPend_next = 1'b0;
        end
        // Filler data for illegal reads
        if (cmdStart && cmdInfo.isRead && (cmdIllegal || accIllegal)) begin
            readData_next = FILL_BYTE;
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (startAcc) begin
                    state_next = ST_WAIT_CYCLE;
                    writeAcc_next = cmdInfo.isWrite;
                    readAcc_next = cmdInfo.isRead;
                end
            end
            ST_WAIT_CYCLE: begin
                if (timeout) begin
                    state_next = ST_ACK;
                    ackCnt_next = LONG_LOAD;
                end else if (looseLate || setOverrun) begin
                    state_next = ST_IDLE;
                end else if (modeInfo.stealSelect || freeCycle) begin
                    state_next = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (accDone) begin
                    readData_next = accRdData;
                    abortPend_next = 1'b0;
                    state_next = modeInfo.ackEnable ? ST_ACK : ST_IDLE;
                    ackCnt_next = ACK_LOAD;
                end else if (accAbort) begin
                    abortPend_next = 1'b0;
                    state_next = ST_IDLE;
                end else if (looseLate || setOverrun) begin
                    abortPend_next = 1'b1;
                end
            end
            ST_ACK: begin
                if (ackCnt_reg == '0) begin
                    state_next = ST_IDLE;
                end else begin
                    ackCnt_next = ackCnt_reg - ACK_CNT_W'(1);
                end
            end
        endcase
    end

    // Register all state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            ackCnt_reg <= '0;
            overrun_reg <= STATUS_RESET[OVERRUN_BIT];
            no_response_flag_reg <= STATUS_RESET[NO_RESPONSE_BIT];
            readInv_reg <= STATUS_RESET[READ_INVALID_BIT];
            illegal_access_flag_reg <= STATUS_RESET[ILLEGAL_ACCESS_BIT];
            illegal_command_flag_reg <= STATUS_RESET[ILLEGAL_COMMAND_BIT];
            abortPend_reg <= 1'b0;
            writeAcc_reg <= 1'b0;
            readAcc_reg <= 1'b0;
            enterPend_reg <= 1'b0;
            readData_reg <= STATUS_RESET;
        end else begin
            state_reg <= state_next;
            ackCnt_reg <= ackCnt_next;
            overrun_reg <= overrun_next;
            no_response_flag_reg <= no_response_flag_next;
            readInv_reg <= readInv_next;
            illegal_access_flag_reg <= illegal_access_flag_next;
            illegal_command_flag_reg <= illegal_command_flag_next;
            abortPend_reg <= abortPend_next;
            writeAcc_reg <= writeAcc_next;
            readAcc_reg <= readAcc_next;
            enterPend_reg <= enterPend_next;
            readData_reg <= readData_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign accReq = (state_reg == ST_ACCESS) && !overrun_reg;
    assign accSteal = accReq && modeInfo.stealSelect;
    assign accAbort = (state_reg == ST_ACCESS) && abortPend_reg && !externalWait;
    assign enterDebugReq = enterPend_reg && !modeInfo.waitMode;
    // Pin driven low only during the acknowledge pulse
    assign debugPinOut = 1'b0;
    assign debugPinOeN = (state_reg != ST_ACK);
    assign statusLow = {3'b000, overrun_reg, no_response_flag_reg, readInv_reg, illegal_access_flag_reg, illegal_command_flag_reg};
    assign readData = readData_reg;

    //////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    overrun_sticky_a: assert property (overrun_reg && !syncSeen |=> overrun_reg)
        else $error("overrun cleared without sync");
    overrun_blocks_a: assert property (overrun_reg |-> !accReq)
        else $error("access requested while overrun");
    cmd_overrun_a: assert property (cmdStart && state_reg == ST_ACK |=> overrun_reg)
        else $error("command during acknowledge missed overrun");
    timeout_long_a: assert property (timeout |=> state_reg == ST_ACK && no_response_flag_reg
        && ackCnt_reg == LONG_LOAD)
        else $error("timeout without long acknowledge");
    w1c_keep_a: assert property (statusWr && !statusWrData[ILLEGAL_COMMAND_BIT] && illegal_command_flag_reg
        |=> illegal_command_flag_reg)
        else $error("write of zero cleared illegal command");
    ecc_flag_a: assert property (state_reg == ST_ACCESS && accDone && readAcc_reg && eccError
        |=> readInv_reg && readData_reg == $past(accRdData))
        else $error("ecc read not flagged or data altered");
    illegal_fill_a: assert property (cmdStart && cmdInfo.isRead && cmdInfo.opcodeUnimpl
        |=> illegal_command_flag_reg && readData_reg == FILL_BYTE)
        else $error("illegal read did not return filler");
    wait_abort_a: assert property (externalWait |-> !accAbort)
        else $error("abort during external wait");
    stop_refuse_a: assert property (cmdStart && stopRefuse |=> no_response_flag_reg && state_reg == ST_IDLE)
        else $error("stop mode access not refused");

    w1c_no_response_flag_a: assert property (statusWr && statusWrData[NO_RESPONSE_BIT] && !setNoResp
        |=> !no_response_flag_reg)
        else $error("write of one left no-response set");

    illegal_access_a: assert property (cmdStart && accIllegal |=> illegal_access_flag_reg)
        else $error("illegal access not flagged");

    free_only_a: assert property (state_reg == ST_WAIT_CYCLE && !modeInfo.stealSelect
        && !freeCycle |=> !accReq)
        else $error("access taken without free cycle or steal");

    blocked_start_a: assert property (cmdStart && overrun_reg && state_reg == ST_IDLE
        |=> state_reg == ST_IDLE)
        else $error("access started while overrun");

endmodule : dlef_error_flags

// >>> dv/dlef_host_pod.sv
/*
 * Debug host pod model: owns the single-wire pin and its pull-up, and
 * measures each low pulse that the device drives.
 * Assumes the device drives only low, with an active-low output enable.
 */
`timescale 1ns/1ns
module dlef_host_pod (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Device side of the pin
    input wire logic devOut,
    input wire logic devOeN,
    output logic pinLevel,
    // Bench control and observation
    input wire logic hostPull,
    output int ackLen
);
    int run;

    //////////////////////////////////////////////////////////////////////////
    // Wire level: pulled up, low when either party drives low
    assign pinLevel = !(hostPull || (!devOeN && !devOut));

    // Counts core clocks of each device pulse; host only pulls when told
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            run = 0;
            ackLen = 0;
        end else if (!devOeN) begin
            run = run + 1;
        end else if (run != 0) begin
            ackLen = run;
            run = 0;
        end
    end
endmodule : dlef_host_pod

// >>> dv/debug_link_error_flags_tb.sv
/*
 * Self-checking bench of the debug link error flags: reads, timeouts,
 * illegal commands, power modes, aborts and overrun.
 * Assumes shortened counts through the block parameters.
 */
`timescale 1ns/1ns
module debug_link_error_flags_tb;
    import dlef_pkg::*;
    localparam int TO = 16;
    localparam int AL = 4;
    localparam int LAL = 12;
    logic ref_clk, nrst, pinLevel, hostPull, cmdStart, hostRetrieve, syncSeen, statusWr;
    logic freeCycle, accDone, eccError, externalWait, busHold, ecc;
    logic debugPinOut, debugPinOeN, accReq, accSteal, accAbort, enterDebugReq;
    logic [7:0] statusWrData, accRdData, statusLow, readData, expData;
    dlef_cmd_s cmdInfo, rd, c;
    dlef_mode_s modeInfo, base;
    int failures, check_count, ackLen, busDelay, accCount, abortCount, n, k0, a0;

    dlef_error_flags #(.TIMEOUT(TO), .ACK_LEN(AL), .LONG_ACK_LEN(LAL)) uut (
        .ref_clk, .nrst, .debugPinIn(pinLevel), .debugPinOut, .debugPinOeN, .cmdStart, .cmdInfo,
        .hostRetrieve, .syncSeen, .statusWr, .statusWrData, .modeInfo, .freeCycle, .accDone,
        .eccError, .externalWait, .accRdData, .accReq, .accSteal, .accAbort, .enterDebugReq,
        .statusLow, .readData);
    dlef_host_pod pod (.ref_clk, .nrst, .devOut(debugPinOut), .devOeN(debugPinOeN), .pinLevel,
        .hostPull, .ackLen);

    //////////////////////////////////////////////////////////////////////////
    // Core clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Aborts counted at the rising edge, where the device acts on them
    always @(posedge ref_clk) begin
        if (accAbort) abortCount <= abortCount + 1;
    end

    // Core bus model: random delay and data, lines scrambled when idle
    always @(negedge ref_clk) begin
        if (accReq) chk({7'h0, accSteal}, {7'h0, modeInfo.stealSelect});
        if (accReq && !accDone && !busHold && busDelay == 0) begin
            expData = 8'($urandom);
            accRdData <= expData;
            eccError <= ecc;
            accDone <= 1'b1;
            accCount <= accCount + 1;
        end else begin
            if (accReq && !busHold && busDelay > 0) busDelay <= busDelay - 1;
            accRdData <= ~accRdData;
            eccError <= ~eccError;
            accDone <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=0x%h exp=0x%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic send(input dlef_cmd_s cmd);
        tick(1);
        cmdInfo = cmd;
        cmdStart = 1'b1;
        tick(1);
        cmdStart = 1'b0;
        cmdInfo = ~cmd;
    endtask : send

    task automatic wr(input logic [7:0] d);
        tick(1);
        statusWr = 1'b1;
        statusWrData = d;
        tick(1);
        statusWr = 1'b0;
        statusWrData = ~d;
    endtask : wr

    task automatic flags(input logic [7:0] e);
        tick(3);
        chk(statusLow, e);
    endtask : flags

    task automatic waitPin(input logic lvl);
        n = 0;
        while (debugPinOeN !== lvl && n < 4 * TO + LAL) begin
            tick(1);
            n++;
        end
        if (n >= 4 * TO + LAL) begin
            failures++;
            $display("[FAIL] t=%0t pin got=0x%h exp=0x%h", $time, debugPinOeN, lvl);
            end_sim();
        end
    endtask : waitPin

    task automatic rst();
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        chk(statusLow, STATUS_RESET);
    endtask : rst

    //////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {nrst, hostPull, cmdStart, hostRetrieve, syncSeen, statusWr, freeCycle} = '0;
        {accDone, eccError, externalWait, busHold, ecc, statusWrData, accRdData} = '0;
        {failures, check_count, busDelay, accCount, abortCount} = '0;
        base = '0;
        base.ackEnable = 1'b1;
        base.stealSelect = 1'b1;
        base.ctrlEnabled = 1'b1;
        base.debugModeActive = 1'b1;
        modeInfo = base;
        rd = '{memAccess: 1'b1, isRead: 1'b1, alwaysAvail: 1'b1, default: 1'b0};
        cmdInfo = '0;
        void'($urandom(32'h0315));
        tick(16);
        nrst = 1'b1;
        chk(statusLow, STATUS_RESET);
        chk({7'h0, debugPinOeN}, 8'h01);
        chk({7'h0, debugPinOut}, 8'h00);
        // Reads through stolen and free cycles, with and without ECC errors
        for (int i = 0; i < 8; i++) begin
            modeInfo.stealSelect = i < 4;
            busDelay = $urandom_range(3);
            ecc = i[0];
            send(rd);
            if (!modeInfo.stealSelect) begin
                tick(6);
                chk({7'h0, accReq}, 8'h00);
                freeCycle = 1'b1;
            end
            waitPin(1'b0);
            freeCycle = 1'b0;
            chk(readData, expData);
            waitPin(1'b1);
            tick(1);
            chk(8'(ackLen), 8'(AL));
            flags({5'h0, ecc, 2'h0});
            wr(8'($urandom) & 8'hFB);
            flags({5'h0, ecc, 2'h0});
            wr(8'h04);
            flags(8'h00);
        end
        ecc = 1'b0;
        // No free cycle: timeout with a long acknowledge
        send(rd);
        waitPin(1'b0);
        waitPin(1'b1);
        tick(1);
        chk(8'(ackLen), 8'(LAL));
        flags(8'h08);
        wr(8'h08);
        flags(8'h00);
        // Illegal accesses and commands: one flag, filler data for reads, no access
        k0 = accCount;
        for (int k = 0; k < 9; k++) begin
            modeInfo = base;
            modeInfo.debugModeActive = k != 5;
            modeInfo.ctrlEnabled = k != 6;
            modeInfo.massErase = k == 7;
            modeInfo.secured = k == 8;
            c = rd;
            c.alwaysAvail = k < 6;
            case (k)
                0: c.addrUnimpl = 1'b1;
                1: c = '{memAccess: 1'b1, isWrite: 1'b1, flashTarget: 1'b1, alwaysAvail: 1'b1, default: 1'b0};
                2: c = '{cpuRegAccess: 1'b1, isRead: 1'b1, badCpuReg: 1'b1, alwaysAvail: 1'b1, default: 1'b0};
                3: c.opcodeUnimpl = 1'b1;
                4: c.seqIllegal = 1'b1;
                5: c.activeOnly = 1'b1;
                default: c.isWrite = 1'b0;
            endcase
            send(c);
            flags(k < 3 ? 8'h02 : 8'h01);
            if (k != 1) chk(readData, FILL_BYTE);
            waitPin(1'b1);
            wr(8'h03);
        end
        chk(8'(accCount - k0), 8'h00);
        // Stop mode refuses memory access unless the clock is kept
        modeInfo = base;
        modeInfo.stopMode = 1'b1;
        send(rd);
        flags(8'h08);
        waitPin(1'b1);
        wr(8'h08);
        modeInfo.stopClockKeep = 1'b1;
        send(rd);
        waitPin(1'b0);
        chk(readData, expData);
        waitPin(1'b1);
        flags(8'h00);
        // Access unfinished at retrieval: abort held off by the external wait
        modeInfo = base;
        modeInfo.ackEnable = 1'b0;
        busHold = 1'b1;
        send(rd);
        externalWait = 1'b1;
        a0 = abortCount;
        tick(1);
        hostRetrieve = 1'b1;
        tick(1);
        hostRetrieve = 1'b0;
        flags(8'h08);
        chk(8'(abortCount - a0), 8'h00);
        chk({7'h0, accReq}, 8'h01);
        externalWait = 1'b0;
        tick(4);
        chk({7'h0, abortCount != a0}, 8'h01);
        chk({7'h0, accReq}, 8'h00);
        wr(8'h08);
        // Write still running when the next command arrives
        send('{memAccess: 1'b1, isWrite: 1'b1, alwaysAvail: 1'b1, default: 1'b0});
        tick(2);
        send(rd);
        flags(8'h08);
        busHold = 1'b0;
        tick(4);
        wr(8'h08);
        // Wait mode: enter-debug deferred, register access, pending return
        modeInfo = base;
        modeInfo.waitMode = 1'b1;
        send('{enterDebug: 1'b1, alwaysAvail: 1'b1, default: 1'b0});
        flags(8'h08);
        chk({7'h0, enterDebugReq}, 8'h00);
        wr(8'h08);
        send('{cpuRegAccess: 1'b1, isRead: 1'b1, alwaysAvail: 1'b1, default: 1'b0});
        flags(8'h08);
        modeInfo.waitMode = 1'b0;
        #1;
        chk({7'h0, enterDebugReq}, 8'h01);
        tick(2);
        chk({7'h0, enterDebugReq}, 8'h00);
        waitPin(1'b1);
        wr(8'h08);
        modeInfo.awaitWaitReturn = 1'b1;
        send(rd);
        flags(8'h08);
        waitPin(1'b1);
        wr(8'h08);
        modeInfo = base;
        modeInfo.enteringWait = 1'b1;
        modeInfo.debugModeActive = 1'b0;
        send('{singleStep: 1'b1, alwaysAvail: 1'b1, default: 1'b0});
        flags(8'h08);
        rst();
        // Second command during an access: overrun blocks until sync
        modeInfo = base;
        modeInfo.stealSelect = 1'b0;
        k0 = accCount;
        send(rd);
        send(rd);
        freeCycle = 1'b1;
        tick(3);
        chk(statusLow & 8'h10, 8'h10);
        wr(8'h1F);
        send(rd);
        tick(6);
        chk(statusLow & 8'h10, 8'h10);
        chk(8'(accCount - k0), 8'h00);
        freeCycle = 1'b0;
        tick(1);
        syncSeen = 1'b1;
        tick(1);
        syncSeen = 1'b0;
        tick(2);
        chk(statusLow & 8'h10, 8'h00);
        rst();
        // Host pulls the pin while an acknowledge is pending
        send(rd);
        tick(2);
        hostPull = 1'b1;
        tick(2);
        hostPull = 1'b0;
        tick(4);
        chk(statusLow & 8'h10, 8'h10);
        rst();
        end_sim();
    end
endmodule : debug_link_error_flags_tb
